// >>> pkg/pio_pkg.sv
package pio_pkg;

	// port geometry: A..G, flat pin vector packs them from bit 0 upward
	localparam int NUM_PORTS = 7;
	localparam int NUM_PINS = 54;
	localparam int PORT_W [NUM_PORTS] = '{8, 8, 7, 8, 8, 8, 7};
	localparam int PORT_BASE [NUM_PORTS] = '{0, 8, 16, 23, 31, 39, 47};
	localparam logic [7:0] PORT_MASK [NUM_PORTS] =
		'{8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h7F};

	// which pins may be taken by the analog converter / digital peripherals
	localparam logic [7:0] ANA_CAP [NUM_PORTS] =
		'{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] DIG_CAP [NUM_PORTS] =
		'{8'h00, 8'h00, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h7F};

	// port E sharing: bit 7..4 serial clock/out/in/select,
	// bit 3..2 timer one channel one/zero, bit 1..0 serial receive/transmit
	localparam int PE_SER_CLK = 7;
	localparam int PE_CTRL_OUT = 6;
	localparam int PE_CTRL_IN = 5;
	localparam int PE_SER_SEL = 4;
	localparam int PE_TMR_CH1 = 3;
	localparam int PE_TMR_CH0 = 2;
	localparam int PE_RX = 1;
	localparam int PE_TX = 0;

	// apb map: low page holds data/direction, high page the pin controls
	localparam int APB_AW = 12;
	localparam logic [11:0] OFF_DATA = 12'h000;
	localparam logic [11:0] OFF_DIR = 12'h004;
	localparam logic [11:0] LOW_STRIDE = 12'h008;
	localparam logic [11:0] OFF_PULL = 12'h100;
	localparam logic [11:0] OFF_SLEW = 12'h104;
	localparam logic [11:0] OFF_DRIVE = 12'h108;
	localparam logic [11:0] HIGH_STRIDE = 12'h010;

	// reset values; only the slew value is masked to the port width where used
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] PULL_RST = 8'h00;
	localparam logic [7:0] SLEW_RST = 8'hFF;
	localparam logic [7:0] DRIVE_RST = 8'h00;

	typedef enum logic [2:0] {
		KIND_DATA = 3'h0,
		KIND_DIR = 3'h1,
		KIND_PULL = 3'h2,
		KIND_SLEW = 3'h3,
		KIND_DRIVE = 3'h4
	} pio_kind_t;

endpackage

// >>> design/pio_pin_mux.sv
`timescale 1ns/1ns
module pio_pin_mux #(
	parameter int W = 8,
	parameter logic [7:0] ANA_MASK = 8'h00,
	parameter logic [7:0] DIG_MASK = 8'h00
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// port registers
	input wire logic [W-1:0] dir,
	input wire logic [W-1:0] data,
	// peripheral requests
	input wire logic [W-1:0] ana_claim,
	input wire logic [W-1:0] dig_claim,
	input wire logic [W-1:0] dig_oe,
	input wire logic [W-1:0] dig_out,
	// pad side
	output logic [W-1:0] pin_out,
	output logic [W-1:0] pin_oe_n,
	output logic [W-1:0] pin_analog
);
	import pio_pkg::*;

	logic [W-1:0] ana_win;
	logic [W-1:0] dig_win;
	logic [W-1:0] nxt_oe_n;
	logic [W-1:0] nxt_out;
	logic [W-1:0] out_ff;
	logic [W-1:0] oe_n_ff;
	logic [W-1:0] analog_ff;

	// analog beats digital; a pin that cannot be shared ignores requests
	assign ana_win = ana_claim & ANA_MASK[W-1:0];
	assign dig_win = dig_claim & DIG_MASK[W-1:0] & ~ana_win;

	always_comb begin
		// analog pins float: output off
		nxt_oe_n = ~(dig_win & dig_oe | ~ana_win & ~dig_win & dir);
		nxt_out = dig_win & dig_out | ~dig_win & data;
	end

	// reset leaves every pad an undriven gpio input
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			oe_n_ff <= '1;
			out_ff <= '0;
			analog_ff <= '0;
		end else begin
			oe_n_ff <= nxt_oe_n;
			out_ff <= nxt_out;
			analog_ff <= ana_win;
		end
	end

	assign pin_out = out_ff;
	assign pin_oe_n = oe_n_ff;
	assign pin_analog = analog_ff;

	for (genvar i = 0; i < W; i++) begin : g_chk
		chk_analog_wins: assert property (@(posedge mclk) disable iff (rst)
			(ana_claim[i] && ANA_MASK[i]) |=> (pin_oe_n[i] && pin_analog[i]))
			else $error("analog claim did not release pad");
		chk_periph_dir: assert property (@(posedge mclk) disable iff (rst)
			(dig_claim[i] && DIG_MASK[i] && !(ana_claim[i] && ANA_MASK[i]))
			|=> (pin_oe_n[i] == !$past(dig_oe[i])))
			else $error("peripheral direction not followed");
		chk_periph_data: assert property (@(posedge mclk) disable iff (rst)
			(dig_claim[i] && DIG_MASK[i] && dig_oe[i]
			&& !(ana_claim[i] && ANA_MASK[i]))
			|=> (pin_out[i] == $past(dig_out[i])))
			else $error("peripheral output data not used");
		chk_gpio_drive: assert property (@(posedge mclk) disable iff (rst)
			(dir[i] && !(dig_claim[i] && DIG_MASK[i])
			&& !(ana_claim[i] && ANA_MASK[i]))
			|=> (!pin_oe_n[i] && pin_out[i] == $past(data[i])))
			else $error("gpio output not driven from data");
		chk_gpio_input: assert property (@(posedge mclk) disable iff (rst)
			(!dir[i] && !(dig_claim[i] && DIG_MASK[i])) |=> pin_oe_n[i])
			else $error("gpio input pad is driven");
	end

endmodule // pio_pin_mux

// >>> design/pio_ports.sv
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ns
// Overview of operation
// - 54 pins in seven ports: five of eight, two of seven pins
// - any unclaimed pin works as a general-purpose input or output
// - after reset no peripheral holds a pin; gpio logic governs all
// - reset clears every direction bit, so every pin is an input
// - reset sets every slew-limit bit to one
// - reset clears every drive-strength bit, giving low drive
// - reset clears every pullup-enable bit
// - data and direction in the low page; pin controls in high page
// - an enabled sharing peripheral sets the pin direction, not the register
// - a peripheral driving a pin supplies its output value
// - analog converter wins a pin claimed also by a digital peripheral
// - port D shares analog, keyboard and timer clock inputs
// - port E shares serial-peripheral, timer one channels and serial pins
// - port B pins share analog inputs zero to seven in bit order
// - each drive bit selects low (0) or high (1) drive of its pin
module pio_ports (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pio_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// peripheral requests, one bit per flat pin
	input wire logic [pio_pkg::NUM_PINS-1:0] ana_claim,
	input wire logic [pio_pkg::NUM_PINS-1:0] dig_claim,
	input wire logic [pio_pkg::NUM_PINS-1:0] dig_oe,
	input wire logic [pio_pkg::NUM_PINS-1:0] dig_out,
	// pads
	input wire logic [pio_pkg::NUM_PINS-1:0] pad_in,
	output logic [pio_pkg::NUM_PINS-1:0] pad_out,
	output logic [pio_pkg::NUM_PINS-1:0] pad_oe_n,
	output logic [pio_pkg::NUM_PINS-1:0] pad_analog,
	output logic [pio_pkg::NUM_PINS-1:0] pad_pullup,
	output logic [pio_pkg::NUM_PINS-1:0] pad_slew,
	output logic [pio_pkg::NUM_PINS-1:0] pad_drive
);
	import pio_pkg::*;

	logic [7:0] data_ff [NUM_PORTS];
	logic [7:0] dir_ff [NUM_PORTS];
	logic [7:0] pull_ff [NUM_PORTS];
	logic [7:0] slew_ff [NUM_PORTS];
	logic [7:0] drive_ff [NUM_PORTS];
	logic [7:0] pin_lvl [NUM_PORTS];
	logic [7:0] claimed [NUM_PORTS];
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic pslverr_ff;
	logic first_ff;
	logic [6:0] dec_word;
	logic dec_hit;
	pio_kind_t dec_kind;
	logic [2:0] dec_port;
	logic setup_ph;
	logic wr_acc;
	logic [7:0] wr_byte;

	// every register sits at base + port * stride; one word each
	function automatic logic [6:0] pio_decode(input logic [11:0] a);
		logic hit;
		logic [2:0] kind;
		logic [2:0] port;
		logic [11:0] lo;
		logic [11:0] hi;
		hit = 1'b0;
		kind = KIND_DATA;
		port = 3'h0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			lo = 12'(p) * LOW_STRIDE;
			hi = 12'(p) * HIGH_STRIDE;
			if (a == OFF_DATA + lo) begin
				hit = 1'b1; kind = KIND_DATA; port = 3'(p);
			end
			if (a == OFF_DIR + lo) begin
				hit = 1'b1; kind = KIND_DIR; port = 3'(p);
			end
			if (a == OFF_PULL + hi) begin
				hit = 1'b1; kind = KIND_PULL; port = 3'(p);
			end
			if (a == OFF_SLEW + hi) begin
				hit = 1'b1; kind = KIND_SLEW; port = 3'(p);
			end
			if (a == OFF_DRIVE + hi) begin
				hit = 1'b1; kind = KIND_DRIVE; port = 3'(p);
			end
		end
		return {hit, kind, port};
	endfunction

	assign dec_word = pio_decode(paddr);
	assign dec_hit = dec_word[6];
	// enum needs an explicit cast from the packed decode word
	assign dec_kind = pio_kind_t'(dec_word[5:3]);
	assign dec_port = dec_word[2:0];
	assign setup_ph = psel && !penable;
	assign wr_acc = psel && penable && pwrite && dec_hit;
	assign wr_byte = pwdata[7:0] & PORT_MASK[dec_port];

	// zero-wait slave: access phase always completes in one cycle
	assign pready = 1'b1;

	// port register file
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				data_ff[p] <= DATA_RST;
				dir_ff[p] <= DIR_RST;
				pull_ff[p] <= PULL_RST;
				slew_ff[p] <= SLEW_RST & PORT_MASK[p];
				drive_ff[p] <= DRIVE_RST;
			end
		end else if (wr_acc) begin
			unique case (dec_kind)
				KIND_DATA: data_ff[dec_port] <= wr_byte;
				KIND_DIR: dir_ff[dec_port] <= wr_byte;
				KIND_PULL: pull_ff[dec_port] <= wr_byte;
				KIND_SLEW: slew_ff[dec_port] <= wr_byte;
				KIND_DRIVE: drive_ff[dec_port] <= wr_byte;
				default: ;
			endcase
		end
	end

	// read value; an input or claimed pin reports its level, not the latch
	always_comb begin
		nxt_prdata = 32'h0000_0000;
		unique case (dec_kind)
			KIND_DATA: nxt_prdata[7:0] =
				(dir_ff[dec_port] & ~claimed[dec_port] & data_ff[dec_port])
				| (~(dir_ff[dec_port] & ~claimed[dec_port])
				& pin_lvl[dec_port]);
			KIND_DIR: nxt_prdata[7:0] = dir_ff[dec_port];
			KIND_PULL: nxt_prdata[7:0] = pull_ff[dec_port];
			KIND_SLEW: nxt_prdata[7:0] = slew_ff[dec_port];
			KIND_DRIVE: nxt_prdata[7:0] = drive_ff[dec_port];
			default: nxt_prdata = 32'h0000_0000;
		endcase
		if (!dec_hit) begin
			nxt_prdata = 32'h0000_0000;
		end
	end

	// read data and error are captured in setup so they stand all access
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prdata_ff <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else if (setup_ph) begin
			prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
			pslverr_ff <= !dec_hit;
		end
	end

	assign prdata = prdata_ff;
	assign pslverr = pslverr_ff;

	// marks the first cycle after reset release, for checking only
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			first_ff <= 1'b0;
		end else begin
			first_ff <= 1'b1;
		end
	end

	// per-port pad wiring; pin controls bypass the mux so they always apply
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		localparam int B = PORT_BASE[p];
		localparam int W = PORT_W[p];

		always_comb begin
			pin_lvl[p] = 8'h00;
			claimed[p] = 8'h00;
			pin_lvl[p][W-1:0] = pad_in[B +: W];
			claimed[p][W-1:0] = (ana_claim[B +: W] & ANA_CAP[p][W-1:0])
				| (dig_claim[B +: W] & DIG_CAP[p][W-1:0]);
		end

		assign pad_pullup[B +: W] = pull_ff[p][W-1:0];
		assign pad_slew[B +: W] = slew_ff[p][W-1:0];
		assign pad_drive[B +: W] = drive_ff[p][W-1:0];

		// port B analog 0..7, D analog/keyboard/timer clk, E serial/timer
		pio_pin_mux #(
			.W(W),
			.ANA_MASK(ANA_CAP[p]),
			.DIG_MASK(DIG_CAP[p])
		) u_mux (
			.mclk(mclk),
			.rst(rst),
			.dir(dir_ff[p][W-1:0]),
			.data(data_ff[p][W-1:0]),
			.ana_claim(ana_claim[B +: W]),
			.dig_claim(dig_claim[B +: W]),
			.dig_oe(dig_oe[B +: W]),
			.dig_out(dig_out[B +: W]),
			.pin_out(pad_out[B +: W]),
			.pin_oe_n(pad_oe_n[B +: W]),
			.pin_analog(pad_analog[B +: W])
		);

		chk_dir_write: assert property (@(posedge mclk) disable iff (rst)
			(wr_acc && dec_kind == KIND_DIR && dec_port == 3'(p))
			|=> (dir_ff[p] == ($past(pwdata[7:0]) & PORT_MASK[p])))
			else $error("direction write not stored");
		chk_drive_pin: assert property (@(posedge mclk) disable iff (rst)
			(wr_acc && dec_kind == KIND_DRIVE && dec_port == 3'(p))
			|=> (pad_drive[B +: W] == $past(pwdata[W-1:0])))
			else $error("drive write did not reach pads");
		chk_reset_dir: assert property (@(posedge mclk) disable iff (rst)
			!first_ff |-> (dir_ff[p] == 8'h00 && pad_oe_n[B +: W] == '1))
			else $error("pins not inputs after reset");
		chk_reset_slew: assert property (@(posedge mclk) disable iff (rst)
			!first_ff |-> (pad_slew[B +: W] == '1))
			else $error("slew limit not set after reset");
		chk_reset_drive: assert property (@(posedge mclk) disable iff (rst)
			!first_ff |-> (pad_drive[B +: W] == '0))
			else $error("drive not low after reset");
		chk_reset_pull: assert property (@(posedge mclk) disable iff (rst)
			!first_ff |-> (pad_pullup[B +: W] == '0))
			else $error("pullup enabled after reset");
		chk_read_pin: assert property (@(posedge mclk) disable iff (rst)
			(setup_ph && !pwrite && dec_hit && dec_kind == KIND_DATA
			&& dec_port == 3'(p) && dir_ff[p] == 8'h00)
			|=> (prdata[W-1:0] == $past(pad_in[B +: W])))
			else $error("input data read not pin level");

		// register effects, read paths and analog reset state, one port at a time
		chk_data_write: assert property (@(posedge mclk) disable iff (rst)
			(wr_acc && dec_kind == KIND_DATA && dec_port == 3'(p))
			|=> (data_ff[p] == ($past(pwdata[7:0]) & PORT_MASK[p])))
			else $error("data write not stored");
		chk_pull_pin: assert property (@(posedge mclk) disable iff (rst)
			(wr_acc && dec_kind == KIND_PULL && dec_port == 3'(p))
			|=> (pad_pullup[B +: W] == $past(pwdata[W-1:0])))
			else $error("pullup write did not reach pads");
		chk_slew_pin: assert property (@(posedge mclk) disable iff (rst)
			(wr_acc && dec_kind == KIND_SLEW && dec_port == 3'(p))
			|=> (pad_slew[B +: W] == $past(pwdata[W-1:0])))
			else $error("slew write did not reach pads");
		chk_reset_analog: assert property (@(posedge mclk) disable iff (rst)
			!first_ff |-> (pad_analog[B +: W] == '0))
			else $error("analog mode active after reset");
		chk_read_latch: assert property (@(posedge mclk) disable iff (rst)
			(setup_ph && !pwrite && dec_kind == KIND_DATA && dec_hit
			&& dec_port == 3'(p) && dir_ff[p] == PORT_MASK[p]
			&& claimed[p] == 8'h00)
			|=> (prdata[7:0] == $past(data_ff[p])))
			else $error("output data read not latch value");
		chk_read_claimed: assert property (@(posedge mclk) disable iff (rst)
			(setup_ph && !pwrite && dec_kind == KIND_DATA && dec_hit
			&& dec_port == 3'(p) && claimed[p] == PORT_MASK[p])
			|=> (prdata[W-1:0] == $past(pad_in[B +: W])))
			else $error("claimed pin read not pin level");
		chk_read_dir: assert property (@(posedge mclk) disable iff (rst)
			(setup_ph && !pwrite && dec_kind == KIND_DIR && dec_hit
			&& dec_port == 3'(p))
			|=> (prdata == {24'h000000, $past(dir_ff[p])}))
			else $error("direction read wrong");
		chk_read_pull: assert property (@(posedge mclk) disable iff (rst)
			(setup_ph && !pwrite && dec_kind == KIND_PULL && dec_hit
			&& dec_port == 3'(p))
			|=> (prdata == {24'h000000, $past(pull_ff[p])}))
			else $error("pullup read wrong");
		chk_read_slew: assert property (@(posedge mclk) disable iff (rst)
			(setup_ph && !pwrite && dec_kind == KIND_SLEW && dec_hit
			&& dec_port == 3'(p))
			|=> (prdata == {24'h000000, $past(slew_ff[p])}))
			else $error("slew read wrong");
		chk_read_drive: assert property (@(posedge mclk) disable iff (rst)
			(setup_ph && !pwrite && dec_kind == KIND_DRIVE && dec_hit
			&& dec_port == 3'(p))
			|=> (prdata == {24'h000000, $past(drive_ff[p])}))
			else $error("drive read wrong");
		// a refused write must leave the data and direction registers alone
		chk_bad_write: assert property (@(posedge mclk) disable iff (rst)
			(psel && penable && pwrite && !dec_hit)
			|=> (data_ff[p] == $past(data_ff[p])
			&& dir_ff[p] == $past(dir_ff[p])))
			else $error("unmapped write changed a register");
	end

	chk_unmapped_err: assert property (@(posedge mclk) disable iff (rst)
		(setup_ph && !dec_hit) |=> (pslverr && prdata == 32'h0000_0000))
		else $error("unmapped access not flagged");

	chk_hit_no_err: assert property (@(posedge mclk) disable iff (rst)
		(setup_ph && dec_hit) |=> !pslverr)
		else $error("mapped access flagged as error");

	chk_write_no_data: assert property (@(posedge mclk) disable iff (rst)
		(setup_ph && pwrite) |=> (prdata == 32'h0000_0000))
		else $error("write access returned read data");

endmodule // pio_ports

// >>> dv/pio_board_model.sv
`timescale 1ns/1ns
module pio_board_model (
	// clock
	input wire logic mclk,
	// pads from the block
	input wire logic [pio_pkg::NUM_PINS-1:0] pad_out,
	input wire logic [pio_pkg::NUM_PINS-1:0] pad_oe_n,
	input wire logic [pio_pkg::NUM_PINS-1:0] pad_pullup,
	// board drivers
	input wire logic [pio_pkg::NUM_PINS-1:0] ext_en,
	input wire logic [pio_pkg::NUM_PINS-1:0] ext_val,
	output logic [pio_pkg::NUM_PINS-1:0] pad_in
);
	import pio_pkg::*;
	// an undriven pin without pullup toggles, so nobody can rely on it
	logic [NUM_PINS-1:0] float_ff = '0;
	always_ff @(posedge mclk) begin
		float_ff <= ~float_ff;
	end
	assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val)
		| (pad_oe_n & ~ext_en & (pad_pullup | float_ff));
endmodule // pio_board_model

// >>> dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	import pio_pkg::*;
	logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, e;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic [53:0] ana_claim = '0, dig_claim = '0, dig_oe = '0, dig_out = '0;
	logic [53:0] ext_en = '0, ext_val = '0, pad_in, exp_pull;
	logic [53:0] pad_out, pad_oe_n, pad_analog, pad_pullup, pad_slew, pad_drive;
	logic pslverr;
	logic [7:0] v;
	int error_cnt = 0, cmp_count = 0, cyc = 0;
	always #4 mclk = ~mclk;
	pio_ports i_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ana_claim(ana_claim),
		.dig_claim(dig_claim), .dig_oe(dig_oe), .dig_out(dig_out),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
		.pad_analog(pad_analog), .pad_pullup(pad_pullup),
		.pad_slew(pad_slew), .pad_drive(pad_drive));
	pio_board_model i_board (.mclk(mclk), .pad_out(pad_out),
		.pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup), .ext_en(ext_en),
		.ext_val(ext_val), .pad_in(pad_in));
	function automatic logic [7:0] get(logic [53:0] x, int p);
		return 8'(x >> PORT_BASE[p]) & PORT_MASK[p];
	endfunction
	function automatic logic [53:0] at(int p, logic [7:0] x);
		return 54'(x & PORT_MASK[p]) << PORT_BASE[p];
	endfunction
	task report_and_stop;
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task cmp(input logic [53:0] g, input logic [53:0] x);
		cmp_count++;
		if (g !== x) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	// holds the request until pready is seen high, then releases it
	task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge mclk);
		penable <= 1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rd(input logic [11:0] a, input logic [7:0] x);
		apb(0, a, 8'h00);
		cmp(q, {46'h0, x});
		cmp(e, 0);
	endtask
	// pads are registered behind the registers, so give them two edges
	task wt;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			report_and_stop;
		end
	end
	initial begin
		repeat (3) @(posedge mclk);
		rst <= 0;
		ext_en <= '1;
		ext_val <= {27{2'b01}};
		wt;
		cmp(pad_oe_n, '1);
		cmp(pad_slew, '1);
		cmp(pad_drive, '0);
		cmp(pad_pullup, '0);
		cmp(pad_analog, '0);
		for (int p = 0; p < NUM_PORTS; p++) begin
			rd(OFF_DIR + 12'(8 * p), 8'h00);
			rd(OFF_SLEW + 12'(16 * p), PORT_MASK[p]);
			rd(OFF_PULL + 12'(16 * p), 8'h00);
			rd(OFF_DRIVE + 12'(16 * p), 8'h00);
			rd(OFF_DATA + 12'(8 * p), get(ext_val, p));
		end
		for (int p = 0; p < NUM_PORTS; p++) begin
			v = (8'hA5 ^ 8'(p)) & PORT_MASK[p];
			apb(1, OFF_DIR + 12'(8 * p), 8'hFF);
			apb(1, OFF_DATA + 12'(8 * p), 8'hA5 ^ 8'(p));
			wt;
			cmp(get(pad_oe_n, p), 8'h00);
			cmp(get(pad_out, p), v);
			rd(OFF_DATA + 12'(8 * p), v);
			apb(1, OFF_DIR + 12'(8 * p), 8'h0F);
			wt;
			rd(OFF_DATA + 12'(8 * p), (v & 8'h0F) | (get(ext_val, p) & 8'hF0));
		end
		exp_pull = '0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			apb(1, OFF_PULL + 12'(16 * p), 8'h3C);
			apb(1, OFF_SLEW + 12'(16 * p), 8'h96);
			apb(1, OFF_DRIVE + 12'(16 * p), 8'h5A + 8'(p));
			exp_pull = exp_pull | at(p, 8'h3C);
		end
		wt;
		for (int p = 0; p < NUM_PORTS; p++) begin
			cmp(get(pad_slew, p), 8'h96 & PORT_MASK[p]);
			cmp(get(pad_drive, p), (8'h5A + 8'(p)) & PORT_MASK[p]);
		end
		rd(12'h148, 8'h5E);
		@(posedge mclk);
		dig_claim <= at(4, 8'hFF) | at(3, 8'hFF) | at(0, 8'hFF);
		dig_oe <= at(4, 8'hC3) | at(3, 8'hFF) | at(0, 8'hFF);
		dig_out <= at(4, 8'h81);
		ana_claim <= at(1, 8'hFF) | at(3, 8'hF0) | at(0, 8'hFF);
		wt;
		cmp(get(pad_oe_n, 4), 8'h3C);
		cmp(get(pad_out, 4) & 8'hC3, 8'h81);
		cmp(get(pad_analog, 1), 8'hFF);
		cmp(get(pad_oe_n, 1), 8'hFF);
		cmp(get(pad_analog, 3), 8'hF0);
		cmp(get(pad_oe_n, 3), 8'hF0);
		cmp(get(pad_analog, 0), 8'h00);
		cmp(get(pad_oe_n, 0), 8'hF0);
		cmp(pad_pullup, exp_pull);
		rd(OFF_DATA + 12'h020, 8'h81 | (get(ext_val, 4) & 8'h3C));
		apb(0, 12'h200, 8'h00);
		cmp(q, 0);
		cmp(e, 1);
		apb(1, 12'h200, 8'hFF);
		cmp(e, 1);
		rd(OFF_DIR, 8'h0F);
		report_and_stop;
	end
endmodule // tb_top
